// ---- rtl/shcd_pkg.sv ----
// Constants and carrier types for the sleep and health command dispatcher
package shcd_pkg;

    // --------------------------------------------------------------
    // Command opcodes and health-command key values
    // --------------------------------------------------------------
    localparam logic [7:0] SHCD_OP_SLEEP_A = 8'hE6;
    localparam logic [7:0] SHCD_OP_SLEEP_B = 8'h99;
    localparam logic [7:0] SHCD_OP_HEALTH = 8'hB0;
    localparam logic [7:0] SHCD_KEY_MID = 8'h4F;
    localparam logic [7:0] SHCD_KEY_HIGH = 8'hC2;

    // --------------------------------------------------------------
    // Health subcommand codes carried in the features byte
    // --------------------------------------------------------------
    localparam logic [7:0] SHCD_SUB_READ_VALUES = 8'hD0;
    localparam logic [7:0] SHCD_SUB_READ_THRESH = 8'hD1;
    localparam logic [7:0] SHCD_SUB_AUTOSAVE = 8'hD2;
    localparam logic [7:0] SHCD_SUB_SAVE_VALUES = 8'hD3;
    localparam logic [7:0] SHCD_SUB_OFFLINE_NOW = 8'hD4;
    localparam logic [7:0] SHCD_SUB_LOG_READ = 8'hD5;
    localparam logic [7:0] SHCD_SUB_LOG_WRITE = 8'hD6;
    localparam logic [7:0] SHCD_SUB_ENABLE = 8'hD8;
    localparam logic [7:0] SHCD_SUB_DISABLE = 8'hD9;
    localparam logic [7:0] SHCD_SUB_STATUS = 8'hDA;
    localparam logic [7:0] SHCD_SUB_AUTO_OFFLINE = 8'hDB;

    // --------------------------------------------------------------
    // Flag positions in the status and error registers
    // --------------------------------------------------------------
    localparam int SHCD_STAT_BUSY = 7;
    localparam int SHCD_STAT_READY = 6;
    localparam int SHCD_STAT_FAULT = 5;
    localparam int SHCD_STAT_SEEK = 4;
    localparam int SHCD_STAT_DRQ = 3;
    localparam int SHCD_STAT_CORR = 2;
    localparam int SHCD_STAT_INDEX = 1;
    localparam int SHCD_STAT_ERR = 0;
    localparam int SHCD_ERR_ABORT = 2;

    // --------------------------------------------------------------
    // Register values and transfer sizing
    // --------------------------------------------------------------
    localparam logic [7:0] SHCD_STATUS_RST = 8'h50;
    localparam logic [7:0] SHCD_STATUS_BUSY = 8'h80;
    localparam logic [7:0] SHCD_STATUS_XFER = 8'h58;
    localparam logic [7:0] SHCD_STATUS_ABORT = 8'h51;
    localparam logic [7:0] SHCD_ERROR_RST = 8'h00;
    localparam logic [7:0] SHCD_ERROR_ABORT = 8'h04;
    localparam logic [7:0] SHCD_STATUS_ZERO_MASK = 8'h26;
    localparam logic [7:0] SHCD_ERROR_ZERO_MASK = 8'hFB;
    localparam int SHCD_XFER_BYTES = 512;
    localparam int SHCD_CNT_W = 10;
    localparam int SHCD_DATA_W = 8;
    localparam int SHCD_FIFO_DEPTH = 16;

    // Shadow command block as latched by the link logic
    typedef struct packed {
        logic [7:0] features;
        logic [7:0] sector_count;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] command;
    } shcd_cmd_block_type;

endpackage

// ---- rtl/shcd_dispatch.sv ----
// Sleep and health command dispatcher with its data-in FIFO
`timescale 1ns/1ps
// Overview of operation
// R1 - Opcodes E6h and 99h both start the same sleep sequence.
// R2 - Only the sleep command moves the block into its sleep state.
// R3 - Cached writes are flushed to media before spin-down begins.
// R4 - After spin-down the interface goes inactive and ignores commands.
// R5 - Software reset or COMRESET alone wakes the block from sleep.
// R6 - Spindle already stopped: skip spin-down, go straight to sleep.
// R7 - Health command is B0h with keys 4Fh mid and C2h high.
// R8 - Host loads the subcommand into features before the opcode.
// R9 - Subcommand codes D0h-D6h, D8h-DBh are recognised.
// R10 - D0h saves attribute values then sends 512 bytes data-in.
// R11 - D1h fetches thresholds then sends 512 bytes data-in.
// R12 - Unknown subcommand or wrong keys ends with abort and error set.
// R13 - Only abort, busy, ready, seek-complete, DRQ and error bits carry meaning.

// ------------------------------------------------------------------
// Data FIFO
// ------------------------------------------------------------------
module shcd_fifo
    import shcd_pkg::*;
#(
    parameter int WIDTH = SHCD_DATA_W,
    parameter int DEPTH = SHCD_FIFO_DEPTH
)(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clr,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];

    // Extra pointer bit tells full from empty
    assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign out_valid = wr_r != rd_r;
    assign out_data = mem_r[rd_r[AW-1:0]];

    // Pointer advance
    always_comb
    begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        if (in_valid && in_ready)
            wr_nxt = wr_r + 1'b1;
        if (out_valid && out_ready)
            rd_nxt = rd_r + 1'b1;
        if (clr)
        begin
            wr_nxt = '0;
            rd_nxt = '0;
        end
    end

    // Pointer registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Storage, no reset needed on data
    always_ff @(posedge clk_sys)
    begin
        if (in_valid && in_ready)
            mem_r[wr_r[AW-1:0]] <= in_data;
    end
endmodule

// ------------------------------------------------------------------
// Dispatcher
// ------------------------------------------------------------------
module shcd_dispatch
    import shcd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cmd_wr,
    input wire shcd_cmd_block_type cmd_blk,
    input wire logic soft_reset,
    input wire logic comreset,
    input wire logic spindle_stopped,
    output logic flush_req,
    input wire logic flush_done,
    output logic spin_req,
    input wire logic spin_done,
    output logic save_req,
    input wire logic save_done,
    output logic fetch_req,
    input wire logic fetch_done,
    input wire logic [SHCD_DATA_W-1:0] media_data,
    input wire logic media_valid,
    output logic media_ready,
    output logic [SHCD_DATA_W-1:0] host_data,
    output logic host_valid,
    input wire logic host_ready,
    output logic [7:0] command_error_flags,
    output logic [7:0] device_status_flags,
    output logic iface_inactive
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_FLUSH, ST_SPIN, ST_SLEEP, ST_SAVE, ST_FETCH, ST_XFER
    } shcd_state_type;

    shcd_state_type state_r, state_nxt;
    logic [7:0] status_r, status_nxt, error_r, error_nxt;
    logic flush_r, flush_nxt, spin_r, spin_nxt;
    logic save_r, save_nxt, fetch_r, fetch_nxt;
    logic inactive_r, inactive_nxt;
    logic [SHCD_CNT_W-1:0] cnt_r, cnt_nxt;
    logic wake, xfer_open, fifo_in_ready, push, fifo_empty, fifo_valid;
    logic keys_ok;

    // Sleep opcode decode, used by the next-state logic only
    function automatic logic is_sleep_op(input logic [7:0] op);
        return op == SHCD_OP_SLEEP_A || op == SHCD_OP_SLEEP_B;
    endfunction

    // R9 recognised codes; D7h is a hole in the set
    function automatic logic is_sub_code(input logic [7:0] f);
        return (f >= SHCD_SUB_READ_VALUES && f <= SHCD_SUB_LOG_WRITE) ||
               (f >= SHCD_SUB_ENABLE && f <= SHCD_SUB_AUTO_OFFLINE);
    endfunction

    // R7 key check
    assign keys_ok = cmd_blk.lba_mid == SHCD_KEY_MID &&
                     cmd_blk.lba_high == SHCD_KEY_HIGH;
    // R5 wake sources
    assign wake = soft_reset || comreset;
    // Window closes at 512 so a chatty media side cannot overrun
    assign xfer_open = state_r == ST_XFER &&
                       cnt_r < SHCD_CNT_W'(SHCD_XFER_BYTES);
    assign push = xfer_open && media_valid && fifo_in_ready;
    assign media_ready = xfer_open && fifo_in_ready;
    assign fifo_empty = !fifo_valid;
    assign host_valid = fifo_valid;

    // Sector buffer between media and host
    shcd_fifo #(.WIDTH(SHCD_DATA_W), .DEPTH(SHCD_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .clr(wake),
        .in_data(media_data),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data(host_data),
        .out_valid(fifo_valid),
        .out_ready(host_ready)
    );

    // Command sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        status_nxt = status_r;
        error_nxt = error_r;
        flush_nxt = flush_r;
        spin_nxt = spin_r;
        save_nxt = save_r;
        fetch_nxt = fetch_r;
        inactive_nxt = inactive_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE:
            begin
                // R8 features byte is taken with the opcode write
                if (cmd_wr && is_sleep_op(cmd_blk.command))
                begin
                    // R1 R3 both opcodes begin with a flush
                    state_nxt = ST_FLUSH;
                    flush_nxt = 1'b1;
                    status_nxt = SHCD_STATUS_BUSY;
                    error_nxt = SHCD_ERROR_RST;
                end
                else if (cmd_wr && cmd_blk.command == SHCD_OP_HEALTH)
                begin
                    error_nxt = SHCD_ERROR_RST;
                    status_nxt = SHCD_STATUS_RST;
                    // R12 bad keys or code abort at once
                    if (!keys_ok || !is_sub_code(cmd_blk.features))
                    begin
                        status_nxt = SHCD_STATUS_ABORT;
                        error_nxt = SHCD_ERROR_ABORT;
                    end
                    // R10 save values first
                    else if (cmd_blk.features == SHCD_SUB_READ_VALUES)
                    begin
                        state_nxt = ST_SAVE;
                        save_nxt = 1'b1;
                        status_nxt = SHCD_STATUS_BUSY;
                    end
                    // R11 fetch thresholds first
                    else if (cmd_blk.features == SHCD_SUB_READ_THRESH)
                    begin
                        state_nxt = ST_FETCH;
                        fetch_nxt = 1'b1;
                        status_nxt = SHCD_STATUS_BUSY;
                    end
                end
            end
            ST_FLUSH:
            begin
                if (flush_done)
                begin
                    flush_nxt = 1'b0;
                    // R6 stopped spindle skips spin-down
                    if (spindle_stopped)
                    begin
                        state_nxt = ST_SLEEP;
                        inactive_nxt = 1'b1;
                        status_nxt = SHCD_STATUS_RST;
                    end
                    else
                    begin
                        // R3 spin-down only after flush
                        state_nxt = ST_SPIN;
                        spin_nxt = 1'b1;
                    end
                end
            end
            ST_SPIN:
            begin
                if (spin_done)
                begin
                    // R2 R4 sleep path alone sets inactive
                    spin_nxt = 1'b0;
                    state_nxt = ST_SLEEP;
                    inactive_nxt = 1'b1;
                    status_nxt = SHCD_STATUS_RST;
                end
            end
            ST_SLEEP:
            begin
                // R4 commands are ignored here
                state_nxt = ST_SLEEP;
            end
            ST_SAVE, ST_FETCH:
            begin
                if ((state_r == ST_SAVE && save_done) ||
                    (state_r == ST_FETCH && fetch_done))
                begin
                    save_nxt = 1'b0;
                    fetch_nxt = 1'b0;
                    state_nxt = ST_XFER;
                    cnt_nxt = '0;
                    status_nxt = SHCD_STATUS_XFER;
                end
            end
            ST_XFER:
            begin
                // R10 R11 exactly 512 bytes offered
                if (push)
                    cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == SHCD_CNT_W'(SHCD_XFER_BYTES) && fifo_empty)
                begin
                    state_nxt = ST_IDLE;
                    status_nxt = SHCD_STATUS_RST;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        // R5 resets pull the block out of any state
        if (wake)
        begin
            state_nxt = ST_IDLE;
            status_nxt = SHCD_STATUS_RST;
            error_nxt = SHCD_ERROR_RST;
            flush_nxt = 1'b0;
            spin_nxt = 1'b0;
            save_nxt = 1'b0;
            fetch_nxt = 1'b0;
            inactive_nxt = 1'b0;
        end
    end

    // R13 registers load only clean status codes
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_r <= ST_IDLE;
            status_r <= SHCD_STATUS_RST;
            error_r <= SHCD_ERROR_RST;
            flush_r <= 1'b0;
            spin_r <= 1'b0;
            save_r <= 1'b0;
            fetch_r <= 1'b0;
            inactive_r <= 1'b0;
            cnt_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            status_r <= status_nxt;
            error_r <= error_nxt;
            flush_r <= flush_nxt;
            spin_r <= spin_nxt;
            save_r <= save_nxt;
            fetch_r <= fetch_nxt;
            inactive_r <= inactive_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign flush_req = flush_r;
    assign spin_req = spin_r;
    assign save_req = save_r;
    assign fetch_req = fetch_r;
    assign iface_inactive = inactive_r;
    assign command_error_flags = error_r;
    assign device_status_flags = status_r;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // Extra term folds the per-check qualifier into the taken command
    sequence s_idle_take(logic [7:0] op, logic extra);
        state_r == ST_IDLE && cmd_wr && !wake && cmd_blk.command == op
        && extra;
    endsequence

    a_sleep_decode: assert property ( // R1
        (s_idle_take(SHCD_OP_SLEEP_A, 1'b1)
        or s_idle_take(SHCD_OP_SLEEP_B, 1'b1))
        |=> state_r == ST_FLUSH && flush_r && status_r[SHCD_STAT_BUSY])
        else $error("sleep opcode did not start flush");
    a_sleep_entry: assert property ( // R2
        $rose(inactive_r) |-> $past(state_r) == ST_FLUSH
        || $past(state_r) == ST_SPIN)
        else $error("sleep entered outside sleep sequence");
    a_flush_first: assert property ( // R3
        $rose(spin_r) |-> $past(flush_r) && $past(flush_done) && !flush_r)
        else $error("spin-down started before flush done");
    a_sleep_deaf: assert property ( // R4
        state_r == ST_SLEEP && !wake |=> state_r == ST_SLEEP && inactive_r
        && !status_r[SHCD_STAT_BUSY])
        else $error("sleeping block reacted to non-reset input");
    a_wake_path: assert property ( // R5
        state_r == ST_SLEEP && wake |=> state_r == ST_IDLE && !inactive_r
        ##1 !inactive_r)
        else $error("reset did not wake block");
    a_skip_spin: assert property ( // R6
        state_r == ST_FLUSH && flush_done && spindle_stopped && !wake
        |=> state_r == ST_SLEEP && !spin_r)
        else $error("spin-down not skipped");
    a_bad_abort: assert property ( // R12
        s_idle_take(SHCD_OP_HEALTH,
                    !keys_ok || !is_sub_code(cmd_blk.features))
        |=> error_r[SHCD_ERR_ABORT] && status_r[SHCD_STAT_ERR]
        && state_r == ST_IDLE)
        else $error("bad health command not aborted");
    a_sub_accept: assert property ( // R9
        s_idle_take(SHCD_OP_HEALTH,
                    keys_ok && is_sub_code(cmd_blk.features))
        |=> !error_r[SHCD_ERR_ABORT] && !status_r[SHCD_STAT_ERR])
        else $error("listed subcommand was aborted");
    a_values_save: assert property ( // R10
        s_idle_take(SHCD_OP_HEALTH,
                    keys_ok && cmd_blk.features == SHCD_SUB_READ_VALUES)
        |=> save_r && !fetch_r)
        else $error("read values did not save first");
    a_thresh_fetch: assert property ( // R11
        s_idle_take(SHCD_OP_HEALTH,
                    keys_ok && cmd_blk.features == SHCD_SUB_READ_THRESH)
        |=> fetch_r && !save_r)
        else $error("read thresholds did not fetch first");
    a_xfer_count: assert property ( // R10
        state_r == ST_XFER && push |=> cnt_r == $past(cnt_r) + 1'b1
        && cnt_r <= SHCD_CNT_W'(SHCD_XFER_BYTES))
        else $error("data-in byte count wrong");
    a_status_clean: assert property ( // R13
        (status_r & SHCD_STATUS_ZERO_MASK) == 8'h00
        && (error_r & SHCD_ERROR_ZERO_MASK) == 8'h00)
        else $error("unused status or error bit set");
endmodule

// ---- verif/shcd_host_model.sv ----
// Host-side partner: command writer, wake source and data-in sink
`timescale 1ns/1ps
module shcd_host_model
    import shcd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic stall,
    output logic cmd_wr,
    output shcd_cmd_block_type cmd_blk,
    output logic soft_reset,
    output logic comreset,
    input wire logic [SHCD_DATA_W-1:0] host_data,
    input wire logic host_valid,
    output logic host_ready,
    output int rx_count,
    output int rx_bad
);
    // Idle values at time zero
    initial
    begin
        cmd_wr = 1'b0;
        cmd_blk = '0;
        soft_reset = 1'b0;
        comreset = 1'b0;
        host_ready = 1'b0;
        rx_count = 0;
        rx_bad = 0;
    end

    // features and keys ride with the opcode strobe
    task automatic issue(input logic [7:0] feat, input logic [7:0] mid,
                         input logic [7:0] high, input logic [7:0] op);
        @(negedge clk_sys);
        cmd_blk = '{feat, 8'h01, 8'h00, mid, high, op};
        cmd_wr = 1'b1;
        @(negedge clk_sys);
        cmd_wr = 1'b0;
        // Released block shows junk so stale values cannot help
        cmd_blk = ~cmd_blk;
    endtask

    // wake by software reset or link reset
    task automatic wake(input logic use_com);
        @(negedge clk_sys);
        soft_reset = !use_com;
        comreset = use_com;
        @(negedge clk_sys);
        soft_reset = 1'b0;
        comreset = 1'b0;
    endtask

    // Ready follows the stall request, launched on the falling edge, half a cycle before the sampling edge
    always @(negedge clk_sys)
        host_ready <= !stall;

    // Sink checks each byte; pattern repeats every 256 so runs align
    always @(posedge clk_sys)
    begin
        if (host_valid && host_ready)
        begin
            if (host_data !== (rx_count[7:0] ^ 8'h5A))
                rx_bad <= rx_bad + 1;
            rx_count <= rx_count + 1;
        end
    end
endmodule

// ---- verif/shcd_dispatch_tb.sv ----
// Self-checking bench for the sleep and health command dispatcher
`timescale 1ns/1ps
module shcd_dispatch_tb;
    import shcd_pkg::*;

    logic clk_sys, srst, spindle_stopped, stall, media_valid;
    logic cmd_wr, soft_reset, comreset, host_valid, host_ready;
    shcd_cmd_block_type cmd_blk;
    logic flush_req, flush_done, spin_req, spin_done;
    logic save_req, save_done, fetch_req, fetch_done;
    logic media_ready, iface_inactive;
    logic [7:0] media_data, host_data;
    logic [7:0] command_error_flags, device_status_flags;
    logic [15:0] fl_sr, sp_sr, sv_sr, fe_sr, msk;
    logic flushed, spun, prep, order_bad;
    int dly, media_cnt, rx_count, rx_bad, errors, comparisons, cycles;

    shcd_dispatch dut (.clk_sys(clk_sys), .srst(srst), .cmd_wr(cmd_wr),
        .cmd_blk(cmd_blk), .soft_reset(soft_reset), .comreset(comreset),
        .spindle_stopped(spindle_stopped), .flush_req(flush_req),
        .flush_done(flush_done), .spin_req(spin_req),
        .spin_done(spin_done), .save_req(save_req),
        .save_done(save_done), .fetch_req(fetch_req),
        .fetch_done(fetch_done), .media_data(media_data),
        .media_valid(media_valid), .media_ready(media_ready),
        .host_data(host_data), .host_valid(host_valid),
        .host_ready(host_ready),
        .command_error_flags(command_error_flags),
        .device_status_flags(device_status_flags),
        .iface_inactive(iface_inactive));

    shcd_host_model host (.clk_sys(clk_sys), .stall(stall),
        .cmd_wr(cmd_wr), .cmd_blk(cmd_blk), .soft_reset(soft_reset),
        .comreset(comreset), .host_data(host_data),
        .host_valid(host_valid), .host_ready(host_ready),
        .rx_count(rx_count), .rx_bad(rx_bad));

    // 100 ns clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Mechanics answer after dly+1 cycles of request, held as a level
    assign msk = (16'h1 << (dly + 1)) - 16'h1;
    always @(negedge clk_sys)
    begin
        fl_sr <= {fl_sr[14:0], flush_req};
        sp_sr <= {sp_sr[14:0], spin_req};
        sv_sr <= {sv_sr[14:0], save_req};
        fe_sr <= {fe_sr[14:0], fetch_req};
        flush_done <= flush_req && ((fl_sr & msk) == msk);
        spin_done <= spin_req && ((sp_sr & msk) == msk);
        save_done <= save_req && ((sv_sr & msk) == msk);
        fetch_done <= fetch_req && ((fe_sr & msk) == msk);
    end

    // Media offers an endless pattern; only the design may stop it
    assign media_data = media_cnt[7:0] ^ 8'hA5 ^ 8'hFF;
    always @(posedge clk_sys)
        if (media_valid && media_ready)
            media_cnt <= media_cnt + 1;

    // Order watch: spin-down only after flush, data only after prep
    always @(posedge clk_sys)
    begin
        if (flush_req && flush_done)
            flushed <= 1'b1;
        if ((save_req && save_done) || (fetch_req && fetch_done))
            prep <= 1'b1;
        if (spin_req)
            spun <= 1'b1;
        if ((spin_req && !flushed) || (media_ready && !prep))
            order_bad <= 1'b1;
    end

    // Hang guard, well above the roughly 1200 cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            errors++;
            report_and_stop();
        end
    end

    // Wide enough that packed flag-plus-count compares lose no bit
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic clear_flags();
        flushed = 1'b0;
        spun = 1'b0;
        prep = 1'b0;
        order_bad = 1'b0;
    endtask

    task automatic t_reset();
        check(device_status_flags, SHCD_STATUS_RST);
        check(command_error_flags, SHCD_ERROR_RST);
        check({iface_inactive, host_valid, media_ready}, 3'b000);
    endtask

    task automatic t_sleep(input logic [7:0] op, input logic stop,
                           input logic use_com);
        int i;
        spindle_stopped = stop;
        clear_flags();
        host.issue(8'h00, 8'h00, 8'h00, op);
        check(device_status_flags, SHCD_STATUS_BUSY);
        check(flush_req, 1'b1);
        for (i = 0; i < 200 && iface_inactive !== 1'b1; i++)
            @(negedge clk_sys);
        check(iface_inactive, 1'b1);
        check(device_status_flags, SHCD_STATUS_RST);
        check(spun, !stop);
        check(order_bad, 1'b0);
        host.issue(SHCD_SUB_READ_VALUES, SHCD_KEY_MID, SHCD_KEY_HIGH,
                   SHCD_OP_HEALTH);
        repeat (4) @(negedge clk_sys);
        check({save_req, iface_inactive}, 2'b01);
        host.wake(use_com);
        check(iface_inactive, 1'b0);
        check(device_status_flags, SHCD_STATUS_RST);
    endtask

    // Table of features and keys; expectation derived from the code list
    task automatic t_health();
        logic [23:0] tab [15];
        logic ok;
        tab = '{24'hD24FC2, 24'hD34FC2, 24'hD44FC2, 24'hD54FC2,
                24'hD64FC2, 24'hD84FC2, 24'hD94FC2, 24'hDA4FC2,
                24'hDB4FC2, 24'hD74FC2, 24'hDC4FC2, 24'hCF4FC2,
                24'hD24EC2, 24'hD84FC3, 24'hD34FC2};
        foreach (tab[i])
        begin
            ok = ((tab[i][23:16] >= 8'hD2 && tab[i][23:16] <= 8'hD6) ||
                  (tab[i][23:16] >= 8'hD8 && tab[i][23:16] <= 8'hDB)) &&
                 tab[i][15:8] == SHCD_KEY_MID &&
                 tab[i][7:0] == SHCD_KEY_HIGH;
            host.issue(tab[i][23:16], tab[i][15:8], tab[i][7:0],
                       SHCD_OP_HEALTH);
            check(device_status_flags, ok ? 8'h50 : 8'h51);
            check(command_error_flags, ok ? 8'h00 : 8'h04);
            check(iface_inactive, 1'b0);
        end
    endtask

    task automatic t_read(input logic [7:0] feat, input int d);
        int i;
        int base;
        dly = d;
        stall = 1'b1;
        media_cnt = 0;
        base = rx_count;
        clear_flags();
        host.issue(feat, SHCD_KEY_MID, SHCD_KEY_HIGH, SHCD_OP_HEALTH);
        check(device_status_flags, SHCD_STATUS_BUSY);
        check({save_req, fetch_req}, feat[0] ? 2'b01 : 2'b10);
        for (i = 0; i < 100 && device_status_flags !== 8'h58; i++)
            @(negedge clk_sys);
        check(device_status_flags, SHCD_STATUS_XFER);
        repeat (40) @(negedge clk_sys);
        check({media_ready, media_cnt[15:0]}, 17'd16);
        stall = 1'b0;
        for (i = 0; i < 3000 && device_status_flags !== 8'h50; i++)
            @(negedge clk_sys);
        check(rx_count - base, 16'd512);
        check(media_cnt[15:0], 16'd512);
        check(rx_bad[15:0], 16'd0);
        check({order_bad, command_error_flags}, 9'h000);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence: reset held 20 cycles, then each scenario in turn
    initial
    begin
        srst = 1'b1;
        spindle_stopped = 1'b0;
        stall = 1'b0;
        media_valid = 1'b0;
        media_cnt = 0;
        dly = 2;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        clear_flags();
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        media_valid = 1'b1;
        t_reset();
        t_sleep(SHCD_OP_SLEEP_A, 1'b0, 1'b0);
        t_sleep(SHCD_OP_SLEEP_B, 1'b1, 1'b1);
        t_health();
        t_read(SHCD_SUB_READ_VALUES, 9);
        t_read(SHCD_SUB_READ_THRESH, 0);
        report_and_stop();
    end
endmodule
